//--- rtl/bsc_burst_counter.sv
// Purpose: Two-bit wrapping burst counter, interleaved or linear order.
// Assumes: Load and advance are never set in the same cycle.
// Notes: Start address and step are held apart so both orders derive from them.
`timescale 1ns/100ps
module bsc_burst_counter (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Counter port.
   bsc_burst_if.cnt bus
);
   logic [1:0] base_ff;
   logic [1:0] step_ff;
   logic [1:0] nxt_step;

   function automatic logic [1:0] burst_addr(input logic [1:0] base, input logic [1:0] step,
                                             input logic ilv);
      burst_addr = ilv ? (base ^ step) : 2'(base + step);
   endfunction

   assign nxt_step = 2'(step_ff + bsc_pkg::STEP_ONE);
   assign bus.cur_low = burst_addr(base_ff, step_ff, bus.interleave);
   assign bus.next_low = burst_addr(base_ff, nxt_step, bus.interleave);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         base_ff <= bsc_pkg::STEP_RST;
         step_ff <= bsc_pkg::STEP_RST;
      end else if (bus.load) begin
         base_ff <= bus.load_low;
         step_ff <= bsc_pkg::STEP_RST;
      end else if (bus.advance) begin
         step_ff <= nxt_step;
      end
   end
endmodule

//--- rtl/bsc_burst_if.sv
// Purpose: Carries burst counter control and results between decoder and counter.
// Assumes: Counter and decoder share one clock.
// Notes: next_low is the address after one advance step.
`timescale 1ns/100ps
interface bsc_burst_if;
   logic load;
   logic [1:0] load_low;
   logic advance;
   logic interleave;
   logic [1:0] cur_low;
   logic [1:0] next_low;

   modport ctrl (
      output load,
      output load_low,
      output advance,
      output interleave,
      input cur_low,
      input next_low
   );
   modport cnt (
      input load,
      input load_low,
      input advance,
      input interleave,
      output cur_low,
      output next_low
   );
endinterface

//--- rtl/bsc_cycle_decode.sv
// Purpose: Cycle decoder of a pipelined burst SRAM, facing the memory array.
// Assumes: Array read data is valid in the same cycle in which array_rd_o is high.
// Notes: Output enable and sleep act asynchronously on the data drivers.
// Functional notes
// - Processor strobe low with all enables active starts a read, ignoring writes.
// - Controller strobe start with processor strobe high: write if write term low.
// - Controller strobe, or processor strobe with pipelined select low, with any enable inactive gives a deselect with tristated data.
// - Controller strobe high, advance low, no write: read next burst address.
// - Controller strobe high, advance low, write term low: write next address.
// - Controller strobe high, advance high, no write: read current address again.
// - Controller strobe high, advance high, write term low: write current address.
// - Write term active on global write, or gate plus any lane enable.
// - Read when global write high and gate high or all lanes high.
// - Each lane writes its byte and parity; global write writes all lanes.
// - Writes only after a processor strobe start or in a controller start.
// - Output enable is asynchronous; it gates drivers during selected reads.
// - Write cycles mask output enable so data drivers stay off.
// - Sleep input forces power-down and tristate regardless of clock.
// - Next address from two-bit wrap counter, interleaved or linear order.
// - Processor strobe write takes two clocks; data on the second edge.
// - After deselect, outputs stay tristated during the first access cycle.
`timescale 1ns/100ps
module bsc_cycle_decode #(
   parameter int ADDR_W = 18,
   parameter int LANES = 4
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Enables and strobes.
   input wire logic pipelined_select_n_i,
   input wire logic depth_select_high_i,
   input wire logic depth_select_low_n_i,
   input wire logic processor_addr_strobe_n_i,
   input wire logic controller_addr_strobe_n_i,
   input wire logic burst_advance_n_i,
   // Write controls.
   input wire logic global_write_n_i,
   input wire logic byte_write_gate_n_i,
   input wire logic [LANES-1:0] byte_lane_write_n_i,
   // Asynchronous controls and burst order.
   input wire logic output_enable_n_i,
   input wire logic sleep_request_i,
   input wire logic mode_interleave_i,
   // Address.
   input wire logic [ADDR_W-1:0] addr_i,
   // Common data bus and parity lines.
   input wire logic [LANES*8-1:0] data_in_i,
   output logic [LANES*8-1:0] data_out_o,
   output logic data_oe_o,
   input wire logic [LANES-1:0] parity_lines_in_i,
   output logic [LANES-1:0] parity_lines_out_o,
   output logic parity_lines_oe_o,
   // Memory array side.
   output logic [ADDR_W-1:0] array_addr_o,
   output logic array_rd_o,
   output logic [LANES-1:0] array_wr_lanes_o,
   output logic [LANES*8-1:0] array_wdata_o,
   output logic [LANES-1:0] array_wparity_o,
   input wire logic [LANES*8-1:0] array_rdata_i,
   input wire logic [LANES-1:0] array_rparity_i,
   // Decoded operation of the last edge.
   output bsc_pkg::bsc_op_t op_o
);
   bsc_burst_if burst ();

   bsc_pkg::bsc_op_t op;
   bsc_pkg::bsc_op_t op_ff;
   logic [LANES-1:0] lanes;
   logic write_n;
   logic sel_ok;
   logic active_ff;
   logic drive_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [ADDR_W-1:0] nxt_addr;
   logic [ADDR_W-1:0] upper_ff;
   logic rd_ff;
   logic [LANES-1:0] wr_ff;
   logic [LANES*8-1:0] wdata_ff;
   logic [LANES-1:0] wparity_ff;
   logic [LANES*8-1:0] rdata_ff;
   logic [LANES-1:0] rparity_ff;
   logic is_write;
   logic is_read;

   // Decodes the lanes written by the sampled write controls.
   function automatic logic [LANES-1:0] lane_decode(input logic gw_n, input logic gate_n,
                                                    input logic [LANES-1:0] bw_n);
      if (!gw_n) begin
         lane_decode = '1;
      end else if (!gate_n) begin
         lane_decode = ~bw_n;
      end else begin
         lane_decode = '0;
      end
   endfunction

   assign lanes = lane_decode(global_write_n_i, byte_write_gate_n_i, byte_lane_write_n_i);
   assign write_n = ~(|lanes);
   assign sel_ok = ~pipelined_select_n_i & depth_select_high_i & ~depth_select_low_n_i;

   // Cycle decode from the truth table, sleep first.
   always_comb begin
      op = bsc_pkg::OP_DESELECT;
      if (sleep_request_i) begin
         op = bsc_pkg::OP_SLEEP;
      end else if (!processor_addr_strobe_n_i && !pipelined_select_n_i) begin
         if (sel_ok) begin
            op = bsc_pkg::OP_READ_EXT;
         end else begin
            op = bsc_pkg::OP_DESELECT;
         end
      end else if (!controller_addr_strobe_n_i) begin
         if (!sel_ok) begin
            op = bsc_pkg::OP_DESELECT;
         end else if (!write_n) begin
            op = bsc_pkg::OP_WRITE_EXT;
         end else begin
            op = bsc_pkg::OP_READ_EXT;
         end
      end else if (active_ff) begin
         if (!burst_advance_n_i) begin
            op = write_n ? bsc_pkg::OP_READ_NEXT : bsc_pkg::OP_WRITE_NEXT;
         end else begin
            op = write_n ? bsc_pkg::OP_READ_CUR : bsc_pkg::OP_WRITE_CUR;
         end
      end
   end

   assign is_write = (op == bsc_pkg::OP_WRITE_EXT) || (op == bsc_pkg::OP_WRITE_NEXT) ||
                     (op == bsc_pkg::OP_WRITE_CUR);
   assign is_read = (op == bsc_pkg::OP_READ_EXT) || (op == bsc_pkg::OP_READ_NEXT) ||
                    (op == bsc_pkg::OP_READ_CUR);

   // Burst counter control.
   assign burst.load = (op == bsc_pkg::OP_READ_EXT) || (op == bsc_pkg::OP_WRITE_EXT);
   assign burst.load_low = addr_i[1:0];
   assign burst.advance = (op == bsc_pkg::OP_READ_NEXT) || (op == bsc_pkg::OP_WRITE_NEXT);
   assign burst.interleave = mode_interleave_i;

   bsc_burst_counter u_counter (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .bus(burst)
   );

   // Address used by this cycle: external, next or current.
   always_comb begin
      nxt_addr = addr_ff;
      unique case (op)
         bsc_pkg::OP_READ_EXT, bsc_pkg::OP_WRITE_EXT: nxt_addr = addr_i;
         bsc_pkg::OP_READ_NEXT, bsc_pkg::OP_WRITE_NEXT: begin
            nxt_addr = {upper_ff[ADDR_W-1:2], burst.next_low};
         end
         bsc_pkg::OP_READ_CUR, bsc_pkg::OP_WRITE_CUR: begin
            nxt_addr = {upper_ff[ADDR_W-1:2], burst.cur_low};
         end
         bsc_pkg::OP_DESELECT, bsc_pkg::OP_SLEEP: nxt_addr = addr_ff;
      endcase
   end

   // Burst activity: opened by a start, closed by deselect or sleep.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_ff <= bsc_pkg::ACTIVE_RST;
      end else if (burst.load) begin
         active_ff <= 1'b1;
      end else if (op == bsc_pkg::OP_DESELECT || op == bsc_pkg::OP_SLEEP) begin
         active_ff <= 1'b0;
      end
   end

   // Address registers, sampled on the rising edge only.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_ff <= '0;
         upper_ff <= '0;
      end else begin
         addr_ff <= nxt_addr;
         if (burst.load) begin
            upper_ff <= addr_i;
         end
      end
   end

   // Array strobes and write data.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_ff <= 1'b0;
         wr_ff <= '0;
         wdata_ff <= '0;
         wparity_ff <= '0;
      end else begin
         rd_ff <= is_read;
         wr_ff <= is_write ? lanes : '0;
         if (is_write) begin
            wdata_ff <= data_in_i;
            wparity_ff <= parity_lines_in_i;
         end
      end
   end

   // Read data pipeline register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_ff <= '0;
         rparity_ff <= '0;
      end else if (rd_ff) begin
         rdata_ff <= array_rdata_i;
         rparity_ff <= array_rparity_i;
      end
   end

   // Driver permission: only once read data has reached the output register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_ff <= bsc_pkg::DRIVE_RST;
      end else if (is_write) begin
         drive_ff <= 1'b0;
      end else if (op == bsc_pkg::OP_DESELECT || op == bsc_pkg::OP_SLEEP) begin
         drive_ff <= 1'b0;
      end else begin
         drive_ff <= rd_ff;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op_ff <= bsc_pkg::OP_DESELECT;
      end else begin
         op_ff <= op;
      end
   end

   assign op_o = op_ff;
   assign array_addr_o = addr_ff;
   assign array_rd_o = rd_ff;
   assign array_wr_lanes_o = wr_ff;
   assign array_wdata_o = wdata_ff;
   assign array_wparity_o = wparity_ff;
   assign data_out_o = rdata_ff;
   assign parity_lines_out_o = rparity_ff;
   // Output enable and sleep gate the drivers without the clock.
   assign data_oe_o = drive_ff & ~output_enable_n_i & ~sleep_request_i;
   assign parity_lines_oe_o = drive_ff & ~output_enable_n_i & ~sleep_request_i;
endmodule

//--- rtl/bsc_pkg.sv
// Purpose: Shared constants and types of the burst SRAM cycle decoder.
// Assumes: One rising-edge clock, synchronous active-high reset.
// Notes: Burst counter covers the two low address bits.
package bsc_pkg;
   localparam int BURST_W = 2;
   localparam logic [1:0] STEP_RST = 2'h0;
   localparam logic [1:0] STEP_ONE = 2'h1;
   localparam logic DRIVE_RST = 1'h0;
   localparam logic ACTIVE_RST = 1'h0;

   typedef enum logic [2:0] {
      OP_DESELECT,
      OP_SLEEP,
      OP_READ_EXT,
      OP_WRITE_EXT,
      OP_READ_NEXT,
      OP_WRITE_NEXT,
      OP_READ_CUR,
      OP_WRITE_CUR
   } bsc_op_t;
endpackage

//--- sim/bsc_array_model.sv
// Purpose: Memory array model behind the decoder.
// Assumes: Sixteen words, indexed by low address bits.
// Notes: Read data is a toggling pattern when not read.
`timescale 1ns/100ps
module bsc_array_model (
   input wire logic clk_i,
   input wire logic [3:0] addr_i,
   input wire logic rd_i,
   input wire logic [3:0] lanes_i,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wpar_i,
   output logic [31:0] rdata_o,
   output logic [3:0] rpar_o
);
   logic [35:0] mem [16] = '{default: 36'h0};
   logic tog = 1'h0;
   always @(posedge clk_i) begin
      tog <= !tog;
      for (int i = 0; i < 4; i++) begin
         if (lanes_i[i]) begin
            mem[addr_i][8*i +: 8] <= wdata_i[8*i +: 8];
            mem[addr_i][32+i] <= wpar_i[i];
         end
      end
   end
   assign {rpar_o, rdata_o} = rd_i ? mem[addr_i] : {36{tog}};
endmodule

//--- sim/bsc_cycle_decode_assertions.sv
// Purpose: Port checks of the cycle decoder.
// Assumes: One clock, synchronous reset.
// Notes: Bound to every decoder instance.
`timescale 1ns/100ps
module bsc_cycle_decode_assertions #(
   parameter int ADDR_W = 18,
   parameter int LANES = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pipelined_select_n_i,
   input wire logic depth_select_high_i,
   input wire logic depth_select_low_n_i,
   input wire logic processor_addr_strobe_n_i,
   input wire logic controller_addr_strobe_n_i,
   input wire logic global_write_n_i,
   input wire logic byte_write_gate_n_i,
   input wire logic [LANES-1:0] byte_lane_write_n_i,
   input wire logic output_enable_n_i,
   input wire logic sleep_request_i,
   input wire logic mode_interleave_i,
   input wire logic data_oe_o,
   input wire logic [ADDR_W-1:0] array_addr_o,
   input wire logic array_rd_o,
   input wire logic [LANES-1:0] array_wr_lanes_o,
   input bsc_pkg::bsc_op_t op_o
);
   logic sel;
   logic wterm;
   logic wr_op;
   logic nx_op;
   assign sel = !pipelined_select_n_i && depth_select_high_i && !depth_select_low_n_i;
   assign wterm = !global_write_n_i || (!byte_write_gate_n_i && !(&byte_lane_write_n_i));
   assign wr_op = op_o inside {bsc_pkg::OP_WRITE_EXT, bsc_pkg::OP_WRITE_NEXT,
      bsc_pkg::OP_WRITE_CUR};
   assign nx_op = op_o inside {bsc_pkg::OP_READ_NEXT, bsc_pkg::OP_WRITE_NEXT};
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   pstart_read_a: assert property (
      !sleep_request_i && !processor_addr_strobe_n_i && sel
      |=> op_o == bsc_pkg::OP_READ_EXT && array_rd_o && array_wr_lanes_o == '0)
      else $error("processor start did not read");
   ctrl_start_a: assert property (
      !sleep_request_i && processor_addr_strobe_n_i && !controller_addr_strobe_n_i && sel
      |=> op_o == ($past(wterm) ? bsc_pkg::OP_WRITE_EXT : bsc_pkg::OP_READ_EXT))
      else $error("controller start wrong kind");
   deselect_cycle_a: assert property (
      !sleep_request_i && !sel && (!controller_addr_strobe_n_i ||
      (!processor_addr_strobe_n_i && !pipelined_select_n_i)) |=> op_o == bsc_pkg::OP_DESELECT)
      else $error("missing deselect");
   sleep_off_a: assert property (
      sleep_request_i |-> !data_oe_o ##1 op_o == bsc_pkg::OP_SLEEP)
      else $error("sleep did not tristate");
   oe_off_a: assert property (output_enable_n_i |-> !data_oe_o)
      else $error("driving with output enable high");
   write_mask_a: assert property (wr_op |-> !data_oe_o && array_wr_lanes_o != '0)
      else $error("write cycle drives bus");
   suspend_hold_a: assert property (
      op_o inside {bsc_pkg::OP_READ_CUR, bsc_pkg::OP_WRITE_CUR}
      |-> array_addr_o == $past(array_addr_o))
      else $error("suspend moved address");
   linear_step_a: assert property (
      nx_op && !mode_interleave_i |-> array_addr_o[1:0] == $past(array_addr_o[1:0]) + 2'h1
      && array_addr_o[ADDR_W-1:2] == $past(array_addr_o[ADDR_W-1:2]))
      else $error("linear step wrong");
   first_access_a: assert property (
      op_o == bsc_pkg::OP_READ_EXT && $past(op_o) == bsc_pkg::OP_DESELECT |-> !data_oe_o)
      else $error("drive in first access cycle");
   cover property (op_o == bsc_pkg::OP_READ_EXT);
   cover property (op_o == bsc_pkg::OP_WRITE_NEXT);
   cover property (op_o == bsc_pkg::OP_READ_CUR);
   cover property (op_o == bsc_pkg::OP_SLEEP);
endmodule
bind bsc_cycle_decode bsc_cycle_decode_assertions #(.ADDR_W(ADDR_W), .LANES(LANES)) i_chk (
   .clk_i, .rst_i, .pipelined_select_n_i, .depth_select_high_i, .depth_select_low_n_i,
   .processor_addr_strobe_n_i, .controller_addr_strobe_n_i, .global_write_n_i,
   .byte_write_gate_n_i, .byte_lane_write_n_i, .output_enable_n_i, .sleep_request_i,
   .mode_interleave_i, .data_oe_o, .array_addr_o, .array_rd_o, .array_wr_lanes_o, .op_o);

//--- sim/tb_top.sv
// Purpose: Random self-checking bench of the cycle decoder.
// Assumes: Bench model mirrors the array contents.
// Notes: Burst order changes only across a reset.
`timescale 1ns/100ps
module tb_top;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic pipelined_select_n_i, depth_select_high_i, depth_select_low_n_i;
   logic processor_addr_strobe_n_i, controller_addr_strobe_n_i, burst_advance_n_i;
   logic global_write_n_i, byte_write_gate_n_i, output_enable_n_i;
   logic sleep_request_i, mode_interleave_i, data_oe_o, array_rd_o, parity_lines_oe_o;
   logic [3:0] byte_lane_write_n_i, parity_lines_in_i, parity_lines_out_o;
   logic [3:0] array_wr_lanes_o, array_wparity_o, array_rparity_i, elan, ln;
   logic [17:0] addr_i, array_addr_o, ea, hi;
   logic [31:0] data_in_i, data_out_o, array_wdata_o, array_rdata_i;
   logic [35:0] bmem [16] = '{default: 36'h0};
   logic [35:0] ewd, ed;
   logic [1:0] k = 2'h0;
   logic erd = 1'h0;
   logic act = 1'h0;
   logic dv, w, wr, sel;
   bsc_pkg::bsc_op_t op_o, eop;
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;
   always #25 clk_i = !clk_i;
   bsc_cycle_decode i_bsc_cycle_decode (.clk_i, .rst_i, .pipelined_select_n_i,
      .depth_select_high_i, .depth_select_low_n_i, .processor_addr_strobe_n_i,
      .controller_addr_strobe_n_i, .burst_advance_n_i, .global_write_n_i,
      .byte_write_gate_n_i, .byte_lane_write_n_i, .output_enable_n_i, .sleep_request_i,
      .mode_interleave_i, .addr_i, .data_in_i, .data_out_o, .data_oe_o, .parity_lines_in_i,
      .parity_lines_out_o, .parity_lines_oe_o, .array_addr_o, .array_rd_o,
      .array_wr_lanes_o, .array_wdata_o, .array_wparity_o, .array_rdata_i,
      .array_rparity_i, .op_o);
   bsc_array_model i_bsc_array_model (.clk_i, .addr_i(array_addr_o[3:0]), .rd_i(array_rd_o),
      .lanes_i(array_wr_lanes_o), .wdata_i(array_wdata_o), .wpar_i(array_wparity_o),
      .rdata_o(array_rdata_i), .rpar_o(array_rparity_i));
   task chk(input string n, input logic [35:0] s, input logic [35:0] e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task drive;
      logic g;
      logic [4:0] b;
      g = $urandom % 3 != 0;
      b = 5'($urandom);
      global_write_n_i <= g;
      {byte_write_gate_n_i, byte_lane_write_n_i} <= b;
      output_enable_n_i <= !g || (!b[4] && b[3:0] != 4'hf) || $urandom % 4 == 0;
      pipelined_select_n_i <= $urandom % 8 == 0;
      depth_select_high_i <= $urandom % 8 != 0;
      depth_select_low_n_i <= $urandom % 8 == 0;
      processor_addr_strobe_n_i <= $urandom % 4 != 0;
      controller_addr_strobe_n_i <= $urandom % 4 != 0;
      burst_advance_n_i <= 1'($urandom);
      sleep_request_i <= $urandom % 32 == 0;
      addr_i <= 18'($urandom);
      {parity_lines_in_i, data_in_i} <= {4'($urandom), 32'($urandom)};
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 4000) begin
         n_errors++;
         final_report;
      end
   end
   always @(posedge clk_i) begin
      dv = erd && !rst_i;
      if (erd) ed = bmem[ea[3:0]];
      sel = !pipelined_select_n_i && depth_select_high_i && !depth_select_low_n_i;
      w = !global_write_n_i || (!byte_write_gate_n_i && byte_lane_write_n_i != 4'hf);
      ln = global_write_n_i ? ~byte_lane_write_n_i : 4'hf;
      wr = w;
      if (rst_i) eop = bsc_pkg::OP_DESELECT;
      else if (sleep_request_i) eop = bsc_pkg::OP_SLEEP;
      else if (!processor_addr_strobe_n_i && !pipelined_select_n_i) begin
         eop = sel ? bsc_pkg::OP_READ_EXT : bsc_pkg::OP_DESELECT;
         wr = 1'h0;
      end else if (!controller_addr_strobe_n_i) begin
         eop = !sel ? bsc_pkg::OP_DESELECT : w ? bsc_pkg::OP_WRITE_EXT : bsc_pkg::OP_READ_EXT;
      end else if (!act) eop = bsc_pkg::OP_DESELECT;
      else if (!burst_advance_n_i) begin
         eop = w ? bsc_pkg::OP_WRITE_NEXT : bsc_pkg::OP_READ_NEXT;
         k = k + 2'h1;
      end else eop = w ? bsc_pkg::OP_WRITE_CUR : bsc_pkg::OP_READ_CUR;
      if (eop == bsc_pkg::OP_READ_EXT || eop == bsc_pkg::OP_WRITE_EXT) begin
         hi = addr_i;
         k = 2'h0;
      end
      act = eop != bsc_pkg::OP_DESELECT && eop != bsc_pkg::OP_SLEEP;
      erd = act && !wr;
      elan = act && wr ? ln : 4'h0;
      ea = {hi[17:2], mode_interleave_i ? hi[1:0] ^ k : hi[1:0] + k};
      ewd = {parity_lines_in_i, data_in_i};
      for (int i = 0; i < 4; i++) begin
         if (elan[i]) bmem[ea[3:0]][8*i +: 8] = data_in_i[8*i +: 8];
         if (elan[i]) bmem[ea[3:0]][32+i] = parity_lines_in_i[i];
      end
   end
   always @(negedge clk_i) begin
      chk("op", op_o, eop);
      chk("rd", array_rd_o, erd);
      chk("lanes", array_wr_lanes_o, elan);
      if (act) chk("addr", array_addr_o, ea);
      if (elan != 4'h0) chk("wdata", {array_wparity_o, array_wdata_o}, ewd);
      if (dv) chk("dout", {parity_lines_out_o, data_out_o}, ed);
      if (!dv || !erd || output_enable_n_i || sleep_request_i)
         chk("drive off", data_oe_o, 1'h0);
      else chk("drive on", data_oe_o, 1'h1);
      chk("parity drive", parity_lines_oe_o,
         dv && erd && !output_enable_n_i && !sleep_request_i);
   end
   initial begin
      void'($urandom(44));
      drive;
      for (int m = 0; m < 2; m++) begin
         rst_i <= 1'h1;
         mode_interleave_i <= m[0];
         repeat (4) @(posedge clk_i);
         rst_i <= 1'h0;
         repeat (1500) begin
            @(posedge clk_i);
            drive;
         end
         $display("test %0d done", m);
      end
      final_report;
   end
endmodule
